//--- core/rnbs_map.vh
// Constants for the radio network bid scheduler: modes, ranges, timing.
// Assumes inclusion by bare name from the core modules; definitions only.
`ifndef RNBS_MAP_VH
`define RNBS_MAP_VH
// ----------------------------------------------------------------
// Driver modes
// ----------------------------------------------------------------
`define RNBS_DRV_ALWAYS 2'h0
`define RNBS_DRV_FOUR 2'h1
`define RNBS_DRV_HALF 2'h2
`define RNBS_DRV_TWO 2'h3
`define RNBS_OPT_BIT_A 7
`define RNBS_OPT_BIT_B 8
// ----------------------------------------------------------------
// Bid address ranges
// ----------------------------------------------------------------
`define RNBS_BID_ZERO 16'h0000
`define RNBS_BID_100 16'h0064
`define RNBS_BID_200 16'h00C8
`define RNBS_BID_300 16'h012C
`define RNBS_BID_400 16'h0190
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RNBS_CLK_HZ 25000000
`define RNBS_TICK_MS 10
`define RNBS_TICK_CYC ((`RNBS_CLK_HZ / 1000) * `RNBS_TICK_MS)
`define RNBS_TICK_W 18
`define RNBS_CNT_ZERO 16'h0000
`define RNBS_CNT_ONE 16'h0001
`endif

//--- core/rnbs_tick_timer.v
// Loadable down-counter of 10 ms ticks for the bid scheduler.
// Assumes a shared one-cycle tick strobe from the parent.
`timescale 1ns/1ps
`include "rnbs_map.vh"
module rnbs_tick_timer
(
  // Clock and reset
  input wire sys_clk_in,
  input wire rst_in,
  // Control
  input wire load_in,
  input wire [15:0] value_in,
  input wire tick_in,
  // Status
  output reg done_out
);
  reg [15:0] cnt_r; // Ticks left
  reg run_r; // Timer running
  // ----------------------------------------------------------------
  // Countdown; a value of zero finishes on the next clock
  // Done stays up from expiry until the next load, so a late
  // clear-to-send is not lost; the parent masks it while a load waits
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_r <= `RNBS_CNT_ZERO;
      run_r <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      if (load_in)
      begin
        // Restart wins over an expiry in the same cycle
        cnt_r <= value_in;
        run_r <= 1'b1;
        done_out <= 1'b0;
      end
      else if (run_r && cnt_r == `RNBS_CNT_ZERO)
      begin
        run_r <= 1'b0;
        done_out <= 1'b1;
      end
      else if (run_r && tick_in)
      begin
        cnt_r <= cnt_r - `RNBS_CNT_ONE;
      end
    end
  end
endmodule

//--- core/rnbs_core.v
// Radio network port scheduler: bids, retries, handshake, line drivers.
// Assumes synchronous inputs and a message queue that holds one request
// high until it sees a done or error pulse.
`timescale 1ns/1ps
`include "rnbs_map.vh"
module rnbs_core
(
  // Clock and reset
  input wire sys_clk_in,
  input wire rst_in,
  // Configuration
  input wire [1:0] radio_net_port_mode_in,
  input wire [7:0] net_identifier_in,
  input wire master_in,
  input wire [15:0] cts_time_in,
  input wire [15:0] resp_time_in,
  input wire [15:0] bid_interval_in,
  input wire [15:0] retries_in,
  input wire [15:0] pause_time_in,
  input wire [15:0] msg_count_in,
  input wire [15:0] bid_addr_in,
  input wire bid_start_in,
  // Modem handshake
  input wire cts_in,
  // Received frames
  input wire rx_frame_in,
  input wire [7:0] rx_net_id_in,
  // Message queue
  input wire msg_req_in,
  input wire tx_end_in,
  // Transmit side
  output reg rts_out,
  output reg tx_start_out,
  output reg tx_is_bid_out,
  output reg [6:0] tx_addr_out,
  // Queue answers
  output reg msg_done_out,
  output reg msg_err_out,
  output reg rx_accept_out,
  // Line driver
  output reg tx_drv_en_out,
  output reg rx_en_out,
  output reg [15:0] options_out,
  // Visible bid setting
  output reg [15:0] bid_addr_out,
  output reg busy_out
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'h0; // Waiting for work
  localparam ST_CTS = 3'h1; // Clear-to-send wait
  localparam ST_SEND = 3'h2; // Frame on the air
  localparam ST_RESP = 3'h3; // Reply window
  localparam ST_GAP = 3'h4; // Bid interval
  localparam ST_PAUSE = 3'h5; // Transmitter rest
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [`RNBS_TICK_W-1:0] pre_r; // Tick prescaler
  reg tick_r; // One 10 ms strobe
  reg cur_bid_r; // Frame in flight is a bid
  reg [15:0] tries_r; // Retries used
  reg [15:0] sent_r; // Transmissions since last pause
  reg [15:0] start_r; // Starting bid setting
  reg [15:0] base_r; // Range base of active setting
  reg [6:0] addr_r; // Current bid address
  reg bid_act_r; // Automatic bidding active
  reg bid_due_r; // Next bid wanted
  reg replied_r; // Reply seen in window
  reg tmr_load_r;
  reg [15:0] tmr_val_r;
  wire tmr_done;
  wire [15:0] bid_off; // Setting minus its range base
  // ----------------------------------------------------------------
  // Range helpers
  // ----------------------------------------------------------------
  function [15:0] range_base;
    input [15:0] v;
    begin
      if (v >= `RNBS_BID_300 && v < `RNBS_BID_400)
        range_base = `RNBS_BID_300;
      else if (v >= `RNBS_BID_200)
        range_base = `RNBS_BID_200;
      else if (v >= `RNBS_BID_100)
        range_base = `RNBS_BID_100;
      else
        range_base = `RNBS_BID_ZERO;
    end
  endfunction
  function valid_bid;
    input [15:0] v;
    begin
      valid_bid = (v != `RNBS_BID_ZERO) && (v < `RNBS_BID_400);
    end
  endfunction
  assign bid_off = bid_addr_in - range_base(bid_addr_in);
  // ----------------------------------------------------------------
  // Shared timer
  // ----------------------------------------------------------------
  rnbs_tick_timer u_timer
  (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .load_in(tmr_load_r),
    .value_in(tmr_val_r),
    .tick_in(tick_r),
    .done_out(tmr_done)
  );
  // ----------------------------------------------------------------
  // 10 ms tick from the system clock
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pre_r <= {`RNBS_TICK_W{1'b0}};
      tick_r <= 1'b0;
    end
    else if (pre_r == `RNBS_TICK_CYC - 1)
    begin
      // All timers share this tick
      pre_r <= {`RNBS_TICK_W{1'b0}};
      tick_r <= 1'b1;
    end
    else
    begin
      pre_r <= pre_r + 1'b1;
      tick_r <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Line driver enables, registered
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_drv_en_out <= 1'b1;
      rx_en_out <= 1'b1;
      options_out <= 16'h0000;
    end
    else
    begin
      options_out <= 16'h0000;
      case (radio_net_port_mode_in)
        `RNBS_DRV_ALWAYS:
        begin
          tx_drv_en_out <= 1'b1;
          rx_en_out <= 1'b1;
        end
        `RNBS_DRV_FOUR:
        begin
          tx_drv_en_out <= cts_in;
          rx_en_out <= 1'b1;
        end
        `RNBS_DRV_HALF:
        begin
          tx_drv_en_out <= 1'b1;
          rx_en_out <= (state_r != ST_SEND);
        end
        default:
        begin
          // Two-wire: driver floats unless clear-to-send
          tx_drv_en_out <= cts_in;
          rx_en_out <= ~cts_in;
          options_out[`RNBS_OPT_BIT_A] <= 1'b1;
          options_out[`RNBS_OPT_BIT_B] <= 1'b1;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (msg_req_in || (master_in && bid_due_r))
          state_nxt = ST_CTS;
      ST_CTS:
        // Minimum wait elapsed and modem ready; a pending load masks done
        if (tmr_done && !tmr_load_r && cts_in)
          state_nxt = ST_SEND;
      ST_SEND:
        if (tx_end_in)
          state_nxt = ST_RESP;
      ST_RESP:
        // Bids hold the whole window; messages end on reply
        if ((tmr_done && !tmr_load_r) || (replied_r && !cur_bid_r))
          state_nxt = ST_GAP;
      ST_GAP:
        if (tmr_done && !tmr_load_r)
          state_nxt = ST_IDLE;
      ST_PAUSE:
        if (tmr_done && !tmr_load_r)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_r <= ST_IDLE;
      cur_bid_r <= 1'b0;
      tries_r <= `RNBS_CNT_ZERO;
      sent_r <= `RNBS_CNT_ZERO;
      start_r <= `RNBS_BID_ZERO;
      base_r <= `RNBS_BID_ZERO;
      addr_r <= 7'h00;
      bid_act_r <= 1'b0;
      bid_due_r <= 1'b0;
      replied_r <= 1'b0;
      tmr_load_r <= 1'b0;
      tmr_val_r <= `RNBS_CNT_ZERO;
      rts_out <= 1'b0;
      tx_start_out <= 1'b0;
      tx_is_bid_out <= 1'b0;
      tx_addr_out <= 7'h00;
      msg_done_out <= 1'b0;
      msg_err_out <= 1'b0;
      rx_accept_out <= 1'b0;
      bid_addr_out <= `RNBS_BID_ZERO;
      busy_out <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      tmr_load_r <= 1'b0;
      tx_start_out <= 1'b0;
      msg_done_out <= 1'b0;
      msg_err_out <= 1'b0;
      // Only our own network is heard
      rx_accept_out <= rx_frame_in && (rx_net_id_in == net_identifier_in);
      busy_out <= (state_nxt != ST_IDLE);
      if (state_r == ST_RESP && rx_frame_in && rx_net_id_in == net_identifier_in)
        replied_r <= 1'b1;
      // Bid start latches the setting; visible value follows it
      if (bid_start_in && master_in && state_r == ST_IDLE)
      begin
        start_r <= bid_addr_in;
        base_r <= range_base(bid_addr_in);
        addr_r <= bid_off[6:0];
        bid_addr_out <= bid_addr_in;
        bid_act_r <= valid_bid(bid_addr_in);
        bid_due_r <= valid_bid(bid_addr_in);
      end
      case (state_r)
        ST_IDLE:
          if (state_nxt == ST_CTS)
          begin
            // Queued normal messages go ahead of bids
            cur_bid_r <= ~msg_req_in;
            tx_is_bid_out <= ~msg_req_in;
            tx_addr_out <= addr_r;
            rts_out <= 1'b1;
            tmr_val_r <= cts_time_in;
            tmr_load_r <= 1'b1;
          end
        ST_CTS:
          if (state_nxt == ST_SEND)
            tx_start_out <= 1'b1;
        ST_SEND:
          if (state_nxt == ST_RESP)
          begin
            rts_out <= 1'b0;
            replied_r <= 1'b0;
            tmr_val_r <= resp_time_in;
            tmr_load_r <= 1'b1;
            if (msg_count_in != `RNBS_CNT_ZERO)
              sent_r <= sent_r + `RNBS_CNT_ONE;
          end
        ST_RESP:
          if (state_nxt == ST_GAP)
          begin
            tmr_val_r <= master_in ? bid_interval_in : `RNBS_CNT_ZERO;
            tmr_load_r <= 1'b1;
            if (cur_bid_r)
            begin
              // Advance the bid pattern after its window
              bid_due_r <= 1'b0;
              if (base_r == `RNBS_BID_ZERO)
                bid_act_r <= 1'b0;
              else if (base_r == `RNBS_BID_200)
                bid_due_r <= 1'b1;
              else if (addr_r != 7'h00)
              begin
                addr_r <= addr_r - 7'h01;
                bid_due_r <= 1'b1;
                if (base_r == `RNBS_BID_100)
                  bid_addr_out <= bid_addr_out - `RNBS_CNT_ONE;
              end
              else if (base_r == `RNBS_BID_300)
              begin
                // Wrap; visible value never moved
                addr_r <= start_r[6:0] - base_r[6:0];
                bid_due_r <= 1'b1;
              end
              else
                bid_act_r <= 1'b0;
            end
            else if (replied_r)
            begin
              tries_r <= `RNBS_CNT_ZERO;
              msg_done_out <= 1'b1;
            end
            else if (!master_in || tries_r >= retries_in)
            begin
              // Slaves never retry
              tries_r <= `RNBS_CNT_ZERO;
              msg_err_out <= 1'b1;
            end
            else
              tries_r <= tries_r + `RNBS_CNT_ONE;
          end
        ST_GAP:
          if (tmr_done && !tmr_load_r && master_in && msg_count_in != `RNBS_CNT_ZERO
              && sent_r >= msg_count_in)
          begin
            // Rest the transmitter
            state_r <= ST_PAUSE;
            busy_out <= 1'b1;
            sent_r <= `RNBS_CNT_ZERO;
            tmr_val_r <= pause_time_in;
            tmr_load_r <= 1'b1;
          end
        default:
        begin
        end
      endcase
    end
  end
endmodule

//--- tb/rnbs_core_properties.sv
// Checker for the bid scheduler: line drivers, net filter, bid addresses.
// Assumes a bind into rnbs_core; it sees only that module's ports.
`timescale 1ns/1ps
module rnbs_core_properties
(
  // Clock and reset
  input wire sys_clk_in,
  input wire rst_in,
  // Watched inputs
  input wire [1:0] radio_net_port_mode_in,
  input wire [7:0] net_identifier_in,
  input wire cts_in,
  input wire rx_frame_in,
  input wire [7:0] rx_net_id_in,
  // Watched outputs
  input wire rts_out,
  input wire tx_start_out,
  input wire tx_is_bid_out,
  input wire [6:0] tx_addr_out,
  input wire rx_accept_out,
  input wire tx_drv_en_out,
  input wire rx_en_out,
  input wire [15:0] options_out,
  input wire [15:0] bid_addr_out,
  input wire busy_out
);
  // ------
  // Helpers
  // ------
  // High from the second edge after reset, since outputs lag inputs by one
  reg live_r;
  wire [1:0] mode_w = radio_net_port_mode_in;
  wire bid_w = tx_start_out && tx_is_bid_out;
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      live_r <= 1'b0;
    else
      live_r <= 1'b1;
  end
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  // ------
  // Assertions
  // ------
  chk_drive_always: assert property (
    live_r && $past(mode_w) == 2'h0 |-> tx_drv_en_out) else $error("Driver off");
  chk_four_float: assert property (
    live_r && $past(mode_w) == 2'h1 && !$past(cts_in) |-> !tx_drv_en_out) else $error("Driver on");
  chk_two_wire_turn: assert property (
    live_r && $past(mode_w) == 2'h3 |-> tx_drv_en_out == $past(cts_in) &&
    rx_en_out == !$past(cts_in)) else $error("Two-wire enables wrong");
  chk_two_wire_opts: assert property (
    live_r && $past(mode_w) == 2'h3 |-> options_out[8:7] == 2'h3) else $error("Option bits");
  chk_half_quiet: assert property (
    live_r && $past(mode_w) == 2'h2 && $past(tx_start_out) |-> !rx_en_out)
    else $error("Receiver on while sending");
  chk_net_filter: assert property (
    live_r |-> rx_accept_out == ($past(rx_frame_in) &&
    $past(rx_net_id_in) == $past(net_identifier_in))) else $error("Net filter wrong");
  chk_cts_first: assert property (
    tx_start_out |-> rts_out && $past(cts_in)) else $error("Frame before clear-to-send");
  chk_down_addr: assert property (
    bid_w && bid_addr_out >= 16'h0064 && bid_addr_out < 16'h00C8
    |-> tx_addr_out == bid_addr_out - 16'h0064) else $error("Countdown address wrong");
  chk_repeat_addr: assert property (
    bid_w && bid_addr_out >= 16'h00C8 && bid_addr_out < 16'h012C
    |-> tx_addr_out == bid_addr_out - 16'h00C8) else $error("Repeat address wrong");
  chk_wrap_setting: assert property (
    busy_out && bid_addr_out >= 16'h012C |=> $stable(bid_addr_out)) else $error("Setting moved");
  cov_bid: cover property (bid_w);
  cov_msg: cover property (tx_start_out && !tx_is_bid_out);
  cov_accept: cover property (rx_accept_out);
endmodule
bind rnbs_core rnbs_core_properties i_rnbs_core_properties
(
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .radio_net_port_mode_in(radio_net_port_mode_in),
  .net_identifier_in(net_identifier_in), .cts_in(cts_in), .rx_frame_in(rx_frame_in),
  .rx_net_id_in(rx_net_id_in), .rts_out(rts_out), .tx_start_out(tx_start_out),
  .tx_is_bid_out(tx_is_bid_out), .tx_addr_out(tx_addr_out), .rx_accept_out(rx_accept_out),
  .tx_drv_en_out(tx_drv_en_out), .rx_en_out(rx_en_out), .options_out(options_out),
  .bid_addr_out(bid_addr_out), .busy_out(busy_out)
);

//--- tb/rnbs_modem_model.sv
// Modem model: answers request-to-send with clear-to-send, ends frames.
// Assumes one frame at a time; the bench picks a prompt or slow answer.
`timescale 1ns/1ps
module rnbs_modem_model
(
  // Clock and reset
  input wire sys_clk_in,
  input wire rst_in,
  // Bench controls: slow answer, clear-to-send held by a far master
  input wire slow_in,
  input wire cts_on_in,
  // Port side
  input wire rts_in,
  input wire tx_start_in,
  output reg cts_out,
  output reg tx_end_out
);
  integer wait_r; // Cycles since request-to-send rose
  integer send_r; // Cycles left in the current frame
  // ------
  // Handshake and frame timing
  // ------
  // Clear-to-send drops with request-to-send unless cts_on_in holds it high, so no stale grant lingers
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wait_r <= 0;
      send_r <= 0;
      cts_out <= 1'b0;
      tx_end_out <= 1'b0;
    end
    else
    begin
      wait_r <= rts_in ? wait_r + 1 : 0;
      cts_out <= cts_on_in || (rts_in && wait_r >= (slow_in ? 30 : 2));
      send_r <= tx_start_in ? 5 : (send_r > 0 ? send_r - 1 : 0);
      tx_end_out <= (send_r == 1);
    end
  end
endmodule

//--- tb/test_rnbs_core.sv
// Bench for rnbs_core: line drivers, net filter, bid patterns, retries.
// Assumes every tick setting at zero, as one tick is 250000 cycles.
`timescale 1ns/1ps
module test_rnbs_core;
  // ------
  // Signals
  // ------
  reg sys_clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg [1:0] radio_net_port_mode_in = 2'h0;
  reg [7:0] net_identifier_in = 8'h00;
  reg [7:0] rx_net_id_in = 8'h00;
  reg [15:0] retries_in = 16'h0000;
  reg [15:0] bid_addr_in = 16'h0000;
  reg [15:0] msg_count_in = 16'h0000;
  reg master_in = 1'b1;
  reg bid_start_in = 1'b0;
  reg rx_frame_in = 1'b0;
  reg msg_req_in = 1'b0;
  reg slow = 1'b0;
  reg cts_on = 1'b0;
  reg watch = 1'b0; // Frame starts are compared only while set
  reg [15:0] exp_v;
  reg [15:0] exp_q[$]; // Expected frames: 16'h01xx bids address xx, 16'h0200 a message
  wire cts_in, tx_end_in, rts_out, tx_start_out, tx_is_bid_out, msg_err_out;
  wire rx_accept_out, tx_drv_en_out, rx_en_out, busy_out, msg_done_out;
  wire [6:0] tx_addr_out;
  wire [15:0] options_out, bid_addr_out;
  integer seed = 32'h0AAAF490;
  integer miscompares = 0;
  integer total_checks = 0;
  integer cyc = 0;
  integer errs = 0;
  integer m, a;
  rnbs_core i_rnbs_core
  (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .radio_net_port_mode_in(radio_net_port_mode_in),
    .net_identifier_in(net_identifier_in), .master_in(master_in), .cts_time_in(16'h0000),
    .resp_time_in(16'h0000), .bid_interval_in(16'h0000), .retries_in(retries_in),
    .pause_time_in(16'h0000), .msg_count_in(msg_count_in), .bid_addr_in(bid_addr_in),
    .bid_start_in(bid_start_in), .cts_in(cts_in), .rx_frame_in(rx_frame_in),
    .rx_net_id_in(rx_net_id_in), .msg_req_in(msg_req_in), .tx_end_in(tx_end_in),
    .rts_out(rts_out), .tx_start_out(tx_start_out), .tx_is_bid_out(tx_is_bid_out),
    .tx_addr_out(tx_addr_out), .msg_done_out(msg_done_out), .msg_err_out(msg_err_out),
    .rx_accept_out(rx_accept_out), .tx_drv_en_out(tx_drv_en_out), .rx_en_out(rx_en_out),
    .options_out(options_out), .bid_addr_out(bid_addr_out), .busy_out(busy_out)
  );
  rnbs_modem_model i_rnbs_modem_model
  (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .slow_in(slow), .cts_on_in(cts_on),
    .rts_in(rts_out), .tx_start_in(tx_start_out), .cts_out(cts_in), .tx_end_out(tx_end_in)
  );
  always #20 sys_clk_in = ~sys_clk_in;
  // ------
  // Tasks and frame monitor
  // ------
  task check(input [15:0] seen, input [15:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Inputs always move 2 ns after the edge, clear of the sampling point
  task step(input integer n);
    repeat (n)
      @(posedge sys_clk_in);
    #2;
  endtask
  task restart;
    rst_in = 1'b1;
    msg_req_in = 1'b0;
    master_in = 1'b1;
    retries_in = 16'h0001;
    // Random rest count, zero included; pause time stays at zero ticks
    msg_count_in = 16'($random(seed) & 3);
    slow = 1'b0;
    cts_on = 1'b0;
    errs = 0;
    step(2);
    rst_in = 1'b0;
    step(1);
  endtask
  task start_bids(input [15:0] setting);
    restart;
    bid_addr_in = setting;
    bid_start_in = 1'b1;
    watch = 1'b1;
    step(1);
    bid_start_in = 1'b0;
  endtask
  task drain;
    integer k;
    for (k = 0; k < 3000 && exp_q.size() > 0; k = k + 1)
      step(1);
    check(16'(exp_q.size()), 16'h0000);
  endtask
  // Frame starts while watch is set are matched against the model queue; extras hit 16'hFFFF
  always @(posedge sys_clk_in)
  begin
    cyc = cyc + 1;
    if (msg_err_out === 1'b1)
      errs = errs + 1;
    if (watch && tx_start_out === 1'b1)
    begin
      exp_v = exp_q.size() > 0 ? exp_q.pop_front() : 16'hFFFF;
      check(tx_is_bid_out ? {9'h002, tx_addr_out} : 16'h0200, exp_v);
    end
    if (cyc == 20000)
    begin
      miscompares = miscompares + 1;
      results;
    end
  end
  // ------
  // Scenarios
  // ------
  initial
  begin
    restart;
    for (m = 0; m < 4; m = m + 1)
    begin
      radio_net_port_mode_in = m[1:0];
      repeat (4)
      begin
        a = $random(seed);
        cts_on = a[0];
        step(3);
        check(tx_drv_en_out, m[0] ? cts_in : 1'b1);
      end
    end
    check(options_out[8:7], 2'h3);
    check(rx_en_out, !cts_in);
    $display("Test done: driver modes");
    // Half-duplex from here on, so the receiver mute is exercised
    radio_net_port_mode_in = 2'h2;
    repeat (8)
    begin
      a = $random(seed);
      net_identifier_in = a[7:0];
      rx_net_id_in = a[8] ? a[7:0] : a[15:8];
      rx_frame_in = 1'b1;
      step(1);
      rx_frame_in = 1'b0;
      check(rx_accept_out, rx_net_id_in == net_identifier_in);
      rx_net_id_in = ~rx_net_id_in;
      step(1);
    end
    $display("Test done: net filter");
    for (m = 0; m < 2; m = m + 1)
    begin
      start_bids(m ? 16'h0190 : 16'h0000);
      step(150);
      check(busy_out, 1'b0);
    end
    a = $random(seed);
    a = 1 + ((a & 32'h7FFF) % 99);
    exp_q.push_back(16'h0100 + 16'(a));
    start_bids(16'(a));
    drain;
    step(150);
    check(busy_out, 1'b0);
    for (a = 3; a >= 0; a = a - 1)
      exp_q.push_back(16'h0100 + 16'(a));
    start_bids(16'h0067);
    drain;
    step(150);
    check(bid_addr_out, 16'h0064);
    check(busy_out, 1'b0);
    $display("Test done: single and countdown bids");
    exp_q.push_back(16'h0105);
    exp_q.push_back(16'h0200);
    exp_q.push_back(16'h0200);
    exp_q.push_back(16'h0105);
    start_bids(16'h00CD);
    while (exp_q.size() > 3)
      step(1);
    msg_req_in = 1'b1;
    while (msg_err_out !== 1'b1)
      step(1);
    msg_req_in = 1'b0;
    drain;
    watch = 1'b0;
    check(16'(errs), 16'h0001);
    for (m = 0; m < 6; m = m + 1)
      exp_q.push_back(16'h0102 - 16'(m % 3));
    start_bids(16'h012E);
    drain;
    watch = 1'b0;
    check(bid_addr_out, 16'h012E);
    $display("Test done: repeat, priority and wrap");
    // Far station answers inside the window; message ends with done
    restart;
    rx_net_id_in = net_identifier_in;
    exp_q.push_back(16'h0200);
    watch = 1'b1;
    msg_req_in = 1'b1;
    while (rts_out !== 1'b1)
      step(1);
    while (rts_out !== 1'b0)
      step(1);
    rx_frame_in = 1'b1;
    step(1);
    rx_frame_in = 1'b0;
    step(1);
    check(msg_done_out, 1'b1);
    msg_req_in = 1'b0;
    step(20);
    watch = 1'b0;
    check(16'(errs), 16'h0000);
    check(16'(exp_q.size()), 16'h0000);
    $display("Test done: answered message");
    restart;
    master_in = 1'b0;
    retries_in = 16'h0003;
    slow = 1'b1;
    exp_q.push_back(16'h0200);
    watch = 1'b1;
    msg_req_in = 1'b1;
    while (msg_err_out !== 1'b1)
      step(1);
    msg_req_in = 1'b0;
    step(150);
    watch = 1'b0;
    check(16'(errs), 16'h0001);
    $display("Test done: slave retries");
    results;
  end
endmodule
